// >>> src/ela_consts.svh
// Register offsets, field positions and reset values of the logic analyzer
`ifndef ELA_CONSTS_SVH
`define ELA_CONSTS_SVH

`define ELA_ADDR_CTRL       12'h000
`define ELA_ADDR_STATUS     12'h004
`define ELA_ADDR_IRQ_STAT   12'h008
`define ELA_ADDR_IRQ_MASK   12'h00c
`define ELA_ADDR_RD_IDX     12'h010
`define ELA_ADDR_RD_WORD    12'h014
`define ELA_ADDR_RD_DATA    12'h018
`define ELA_ADDR_CAP_START  12'h01c
`define ELA_ADDR_STIM_BASE  12'h040
`define ELA_STIM_WORDS      16
`define ELA_ADDR_COND_BASE  4'h1

`define ELA_COND_MASK_LO    3'h0
`define ELA_COND_MASK_HI    3'h1
`define ELA_COND_MODE0      3'h2
`define ELA_COND_MODE1      3'h3
`define ELA_COND_MODE2      3'h4
`define ELA_COND_OP         3'h5

`define ELA_CTRL_ARM        0
`define ELA_CTRL_REPEAT     1
`define ELA_CTRL_ABORT      2
`define ELA_CTRL_PRE_LSB    4
`define ELA_CTRL_NCOND_LSB  8

`define ELA_ST_STATE_LSB    0
`define ELA_ST_STAGE_LSB    4
`define ELA_ST_TRIG_SEEN    8

`define ELA_IRQ_TRIG        0
`define ELA_IRQ_DONE        1
`define ELA_IRQ_RST         2'h0

`define ELA_MODE_LOW        2'h0
`define ELA_MODE_HIGH       2'h1
`define ELA_MODE_RISE       2'h2
`define ELA_MODE_FALL       2'h3

`endif

// >>> src/ela_pkg.sv
// Types shared by the logic analyzer modules
package ela_pkg;

   typedef enum logic [1:0] {
      ELA_IDLE,
      ELA_RUN,
      ELA_POST,
      ELA_DONE
   } ela_state_e;

   typedef struct packed {
      logic tck;
      logic tdi;
      logic sel;
      logic capture;
      logic shift;
      logic update;
   } ela_jtag_s;

   typedef struct packed {
      logic        wr;
      logic [11:0] addr;
      logic [31:0] data;
   } ela_jcmd_s;

   typedef struct packed {
      logic [63:0] mask;
      logic [95:0] mode;
      logic        use_or;
   } ela_cond_s;

   typedef struct packed {
      logic        en;
      logic [11:0] addr;
      logic [31:0] data;
      logic [31:0] bm;
   } ela_wr_s;

endpackage : ela_pkg

// >>> src/ela_capture_ram.sv
// Capture sample memory with registered read data
module ela_capture_ram #(
   parameter int W     = 8,
   parameter int DEPTH = 512
) (
   input  wire logic                     clk_i,
   input  wire logic                     wr_en_i,
   input  wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
   input  wire logic [W-1:0]             wr_data_i,
   input  wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
   output logic      [W-1:0]             rd_data_o
);

   logic [W-1:0] mem [DEPTH];

   always_ff @(posedge clk_i) begin
      if (wr_en_i) begin
         mem[wr_addr_i] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i) begin
      rd_data_o <= mem[rd_addr_i];
   end

endmodule : ela_capture_ram

// >>> src/ela_top.sv
// Embedded logic analyzer: trigger sequencer, capture, stimulus, JTAG access
// Function
// - The monitor width is a build parameter from 1 to 4064 bits.
// - The capture depth is a parameter from 512 to 16384, one sample a clock.
// - The trigger channel is a parameter from 1 to 40 bits wide.
// - Up to three trigger conditions must match in order before triggering.
// - Each condition masks trigger bits and reduces matches by AND or OR.
// - Each trigger bit matches on rising edge, falling edge or level.
// - A parameter-given initial condition arms capture from reset.
// - A stimulus vector of 0 to 512 bits drives host values into user logic.
// - Stimulus values stand on the outputs before a capture run starts.
// - Pre-trigger samples are kept in steps of a quarter of the depth.
// - Repeat mode re-arms after each capture once the host has taken it.
// - Monitor samples are written in real time into block memory.
// - The host loads triggers and reads samples over the JTAG port.
// - JTAG access only acts while its user chain is selected.
`include "ela_consts.svh"

module ela_top
   import ela_pkg::*;
#(
   parameter int          MW          = 32,
   parameter int          DEPTH       = 1024,
   parameter int          TW          = 8,
   parameter int          SW          = 8,
   parameter bit          INIT_ARM    = 1'b0,
   parameter logic [1:0]  INIT_NCOND  = 2'h1,
   parameter logic [1:0]  INIT_PRE    = 2'h0,
   parameter logic [63:0] INIT_MASK   = 64'h0,
   parameter logic [95:0] INIT_MODE   = 96'h0,
   parameter bit          INIT_OR     = 1'b0
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  wb_cyc_i,
   input  wire logic                  wb_stb_i,
   input  wire logic                  wb_we_i,
   input  wire logic [11:0]           wb_adr_i,
   input  wire logic [3:0]            wb_sel_i,
   input  wire logic [31:0]           wb_dat_i,
   output logic      [31:0]           wb_dat_o,
   output logic                       wb_ack_o,
   output logic                       irq_o,
   input  wire ela_jtag_s             jtag_i,
   output logic                       jtag_tdo_o,
   input  wire logic [MW-1:0]         mon_i,
   input  wire logic [TW-1:0]         trig_i,
   output logic [(SW>0?SW:1)-1:0]     stim_o
);

   localparam int AW    = $clog2(DEPTH);
   localparam int NWORD = (MW + 31) / 32;
   localparam int PADW  = NWORD * 32;

   // Parameter range checks
   if (MW < 1 || MW > 4064) begin : g_bad_mw
      $error("Monitor width out of range");
   end
   if (DEPTH < 512 || DEPTH > 16384 || (1 << AW) != DEPTH) begin : g_bad_d
      $error("Depth must be a power of two from 512 to 16384");
   end
   if (TW < 1 || TW > 40) begin : g_bad_tw
      $error("Trigger width out of range");
   end
   if (SW < 0 || SW > 512) begin : g_bad_sw
      $error("Stimulus width out of range");
   end

   ela_state_e    state_reg;
   ela_wr_s       wr;
   ela_cond_s     cond_reg [3];
   ela_jtag_s     jsync1_reg;
   ela_jtag_s     jsync2_reg;
   ela_jcmd_s     dr_reg;
   logic          tck_prev_reg;
   logic          upd_prev_reg;
   logic          tck_rise;
   logic          tck_fall;
   logic          upd_rise;
   logic          jw_pend_reg;
   logic [11:0]   jw_addr_reg;
   logic [31:0]   jw_data_reg;
   logic [11:0]   jrd_addr_reg;
   logic          wb_wr;
   logic          ack_reg;
   logic          repeat_reg;
   logic [1:0]    pre_reg;
   logic [1:0]    ncond_reg;
   logic [1:0]    irq_stat_reg;
   logic [1:0]    irq_mask_reg;
   logic [1:0]    irq_set;
   logic [1:0]    irq_clr;
   logic          arm_pulse;
   logic          abort_pulse;
   logic          start_run;
   logic [511:0]  stim_reg;
   logic [AW-1:0] rd_idx_reg;
   logic [6:0]    rd_word_reg;
   logic [AW-1:0] wptr_reg;
   logic [AW-1:0] filled_reg;
   logic [AW-1:0] post_reg;
   logic [AW-1:0] start_reg;
   logic [AW-1:0] pre_target;
   logic [1:0]    stage_reg;
   logic [1:0]    last_stage;
   logic          trig_seen_reg;
   logic [TW-1:0] trig_prev_reg;
   logic [2:0]    cond_hit;
   logic          final_hit;
   logic          cap_we;
   logic [MW-1:0] ram_q;
   logic [PADW-1:0] ram_pad;

   // Write port shared by the bus and the JTAG chain; the bus goes first
   assign wb_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;

   always_comb begin
      wr.en   = wb_wr | jw_pend_reg;
      wr.addr = wb_wr ? wb_adr_i : jw_addr_reg;
      wr.data = wb_wr ? wb_dat_i : jw_data_reg;
      wr.bm   = 32'hffffffff;
      if (wb_wr) begin
         wr.bm = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                  {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
      end
   end

   function automatic logic [31:0] merge(input logic [31:0] old);
      merge = (old & ~wr.bm) | (wr.data & wr.bm);
   endfunction : merge

   function automatic logic [31:0] reg_read(input logic [11:0] a);
      logic [4:0] w;
      logic [1:0] c;
      w = a[6:2] - 5'h10;
      c = a[6:5];
      reg_read = 32'h0;
      if (a[11:8] == `ELA_ADDR_COND_BASE && c != 2'h3) begin
         unique case (a[4:2])
            `ELA_COND_MASK_LO: reg_read = cond_reg[c].mask[31:0];
            `ELA_COND_MASK_HI: reg_read = cond_reg[c].mask[63:32];
            `ELA_COND_MODE0:   reg_read = cond_reg[c].mode[31:0];
            `ELA_COND_MODE1:   reg_read = cond_reg[c].mode[63:32];
            `ELA_COND_MODE2:   reg_read = cond_reg[c].mode[95:64];
            `ELA_COND_OP:      reg_read = {31'h0, cond_reg[c].use_or};
            default:           reg_read = 32'h0;
         endcase
      end else if (a[11:6] == 6'h01) begin
         reg_read = stim_reg[a[5:2]*32 +: 32];
      end else begin
         unique case (a)
            `ELA_ADDR_CTRL: begin
               reg_read[`ELA_CTRL_REPEAT] = repeat_reg;
               reg_read[`ELA_CTRL_PRE_LSB +: 2] = pre_reg;
               reg_read[`ELA_CTRL_NCOND_LSB +: 2] = ncond_reg;
            end
            `ELA_ADDR_STATUS: begin
               reg_read[`ELA_ST_STATE_LSB +: 2] = state_reg;
               reg_read[`ELA_ST_STAGE_LSB +: 2] = stage_reg;
               reg_read[`ELA_ST_TRIG_SEEN] = trig_seen_reg;
            end
            `ELA_ADDR_IRQ_STAT:  reg_read = {30'h0, irq_stat_reg};
            `ELA_ADDR_IRQ_MASK:  reg_read = {30'h0, irq_mask_reg};
            `ELA_ADDR_RD_IDX:    reg_read = 32'(rd_idx_reg);
            `ELA_ADDR_RD_WORD:   reg_read = {25'h0, rd_word_reg};
            `ELA_ADDR_CAP_START: reg_read = 32'(start_reg);
            `ELA_ADDR_RD_DATA: begin
               if (32'(rd_word_reg) < NWORD) begin
                  reg_read = ram_pad[rd_word_reg*32 +: 32];
               end
            end
            default: reg_read = 32'h0;
         endcase
      end
      if (w > 5'h0) begin
         reg_read = reg_read;
      end
   endfunction : reg_read

   // Wishbone slave: ack one cycle after the request, dropped the next
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_reg  <= 1'b0;
         wb_dat_o <= 32'h0;
      end else begin
         ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
         if (wb_cyc_i & wb_stb_i & ~ack_reg & ~wb_we_i) begin
            wb_dat_o <= reg_read(wb_adr_i);
         end
      end
   end
   assign wb_ack_o = ack_reg;

   // JTAG pins cross into the clock domain through two flops
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jsync1_reg   <= '0;
         jsync2_reg   <= '0;
         tck_prev_reg <= 1'b0;
         upd_prev_reg <= 1'b0;
      end else begin
         jsync1_reg   <= jtag_i;
         jsync2_reg   <= jsync1_reg;
         tck_prev_reg <= jsync2_reg.tck;
         upd_prev_reg <= jsync2_reg.update & jsync2_reg.sel;
      end
   end

   assign tck_rise = jsync2_reg.tck & ~tck_prev_reg;
   assign tck_fall = ~jsync2_reg.tck & tck_prev_reg;
   assign upd_rise = jsync2_reg.update & jsync2_reg.sel & ~upd_prev_reg;

   // Data chain: capture read data, shift LSB first, act on update
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dr_reg       <= '0;
         jrd_addr_reg <= 12'h0;
         jtag_tdo_o   <= 1'b0;
      end else begin
         if (tck_rise && jsync2_reg.sel) begin
            if (jsync2_reg.capture) begin
               dr_reg <= {1'b0, jrd_addr_reg, reg_read(jrd_addr_reg)};
            end else if (jsync2_reg.shift) begin
               dr_reg <= {jsync2_reg.tdi, dr_reg[$bits(dr_reg)-1:1]};
            end
         end
         if (tck_fall) begin
            jtag_tdo_o <= dr_reg[0];
         end
         if (upd_rise && !dr_reg.wr) begin
            jrd_addr_reg <= dr_reg.addr;
         end
      end
   end

   // JTAG writes wait one cycle when a bus write takes the port
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         jw_pend_reg <= 1'b0;
         jw_addr_reg <= 12'h0;
         jw_data_reg <= 32'h0;
      end else begin
         if (upd_rise && dr_reg.wr) begin
            jw_pend_reg <= 1'b1;
            jw_addr_reg <= dr_reg.addr;
            jw_data_reg <= dr_reg.data;
         end else if (!wb_wr) begin
            jw_pend_reg <= 1'b0;
         end
      end
   end

   // Control pulses and fields
   assign arm_pulse = wr.en && wr.addr == `ELA_ADDR_CTRL
                      && (wr.data[`ELA_CTRL_ARM] & wr.bm[`ELA_CTRL_ARM]);
   assign abort_pulse = wr.en && wr.addr == `ELA_ADDR_CTRL
                        && (wr.data[`ELA_CTRL_ABORT] & wr.bm[`ELA_CTRL_ABORT]);

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         repeat_reg <= 1'b0;
         pre_reg    <= INIT_PRE;
         ncond_reg  <= INIT_NCOND;
      end else if (wr.en && wr.addr == `ELA_ADDR_CTRL) begin
         repeat_reg <= merge(reg_read(`ELA_ADDR_CTRL))[`ELA_CTRL_REPEAT];
         pre_reg    <= merge(reg_read(`ELA_ADDR_CTRL))[`ELA_CTRL_PRE_LSB +: 2];
         ncond_reg  <= merge(reg_read(`ELA_ADDR_CTRL))[`ELA_CTRL_NCOND_LSB +: 2];
      end
   end

   // Readout pointers
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rd_idx_reg  <= '0;
         rd_word_reg <= 7'h0;
      end else if (wr.en) begin
         if (wr.addr == `ELA_ADDR_RD_IDX) begin
            rd_idx_reg <= AW'(merge(32'(rd_idx_reg)));
         end
         if (wr.addr == `ELA_ADDR_RD_WORD) begin
            rd_word_reg <= merge({25'h0, rd_word_reg})[6:0];
         end
      end
   end

   // Stimulus words stand on the outputs as soon as they are written
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stim_reg <= '0;
      end else if (wr.en && wr.addr[11:6] == 6'h01) begin
         stim_reg[wr.addr[5:2]*32 +: 32] <= merge(stim_reg[wr.addr[5:2]*32 +: 32]);
      end
   end

   if (SW > 0) begin : g_stim
      assign stim_o = stim_reg[(SW>0?SW:1)-1:0];
   end else begin : g_no_stim
      assign stim_o = 1'b0;
   end

   // Trigger condition registers; condition 0 loaded from parameters at reset, conditions 1 and 2 cleared
   for (genvar c = 0; c < 3; c++) begin : g_cond_reg
      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            cond_reg[c].mask   <= (c == 0) ? INIT_MASK : 64'h0;
            cond_reg[c].mode   <= (c == 0) ? INIT_MODE : 96'h0;
            cond_reg[c].use_or <= (c == 0) ? INIT_OR : 1'b0;
         end else if (wr.en && wr.addr[11:8] == `ELA_ADDR_COND_BASE
                      && wr.addr[6:5] == 2'(c)) begin
            unique case (wr.addr[4:2])
               `ELA_COND_MASK_LO: cond_reg[c].mask[31:0]  <= merge(cond_reg[c].mask[31:0]);
               `ELA_COND_MASK_HI: cond_reg[c].mask[63:32] <= merge(cond_reg[c].mask[63:32]);
               `ELA_COND_MODE0:   cond_reg[c].mode[31:0]  <= merge(cond_reg[c].mode[31:0]);
               `ELA_COND_MODE1:   cond_reg[c].mode[63:32] <= merge(cond_reg[c].mode[63:32]);
               `ELA_COND_MODE2:   cond_reg[c].mode[95:64] <= merge(cond_reg[c].mode[95:64]);
               `ELA_COND_OP:      cond_reg[c].use_or <= merge({31'h0, cond_reg[c].use_or})[0];
               default: ;
            endcase
         end
      end
   end

   // Previous trigger value for edge detection
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         trig_prev_reg <= '0;
      end else begin
         trig_prev_reg <= trig_i;
      end
   end

   // Per-bit match and AND/OR reduction of each condition
   for (genvar c = 0; c < 3; c++) begin : g_cond
      logic [TW-1:0] match;
      for (genvar b = 0; b < TW; b++) begin : g_bit
         always_comb begin
            unique case (cond_reg[c].mode[2*b +: 2])
               `ELA_MODE_LOW:  match[b] = ~trig_i[b];
               `ELA_MODE_HIGH: match[b] = trig_i[b];
               `ELA_MODE_RISE: match[b] = trig_i[b] & ~trig_prev_reg[b];
               `ELA_MODE_FALL: match[b] = ~trig_i[b] & trig_prev_reg[b];
            endcase
         end
      end
      assign cond_hit[c] = cond_reg[c].use_or
                           ? |(match & cond_reg[c].mask[TW-1:0])
                           : &(match | ~cond_reg[c].mask[TW-1:0]);
   end

   assign last_stage = (ncond_reg == 2'h0) ? 2'h0
                       : (ncond_reg > 2'h3 ? 2'h2 : ncond_reg - 2'h1);
   assign final_hit  = (state_reg == ELA_RUN) && cond_hit[stage_reg]
                       && stage_reg == last_stage;

   assign start_run = arm_pulse
                      | (state_reg == ELA_DONE && repeat_reg
                         && !irq_stat_reg[`ELA_IRQ_DONE]);
   assign pre_target = {pre_reg, {(AW-2){1'b0}}};
   assign cap_we = (state_reg == ELA_RUN) || (state_reg == ELA_POST);

   // Capture sequencer
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_reg <= INIT_ARM ? ELA_RUN : ELA_IDLE;
      end else if (abort_pulse) begin
         state_reg <= ELA_IDLE;
      end else if (start_run) begin
         state_reg <= ELA_RUN;
      end else begin
         unique case (state_reg)
            ELA_RUN:  if (final_hit) state_reg <= ELA_POST;
            ELA_POST: if (post_reg == AW'(1)) state_reg <= ELA_DONE;
            default:  ;
         endcase
      end
   end

   // Stage walk through the sequential conditions
   always_ff @(posedge clk_i) begin
      if (rst_i || start_run) begin
         stage_reg     <= 2'h0;
         trig_seen_reg <= 1'b0;
      end else if (state_reg == ELA_RUN && cond_hit[stage_reg]) begin
         if (stage_reg == last_stage) begin
            trig_seen_reg <= 1'b1;
         end else begin
            stage_reg <= stage_reg + 2'h1;
         end
      end
   end

   // Write pointer, pre-trigger fill and post-trigger count
   always_ff @(posedge clk_i) begin
      if (rst_i || start_run) begin
         wptr_reg   <= '0;
         filled_reg <= '0;
         post_reg   <= '0;
         start_reg  <= '0;
      end else if (cap_we) begin
         wptr_reg <= wptr_reg + AW'(1);
         if (state_reg == ELA_RUN) begin
            if (filled_reg < pre_target) begin
               filled_reg <= filled_reg + AW'(1);
            end
            if (final_hit) begin
               start_reg <= wptr_reg - filled_reg;
               post_reg  <= AW'(DEPTH - 1) - filled_reg;
            end
         end else begin
            post_reg <= post_reg - AW'(1);
         end
      end
   end

   ela_capture_ram #(
      .W     (MW),
      .DEPTH (DEPTH)
   ) u_ram (
      .clk_i     (clk_i),
      .wr_en_i   (cap_we),
      .wr_addr_i (wptr_reg),
      .wr_data_i (mon_i),
      .rd_addr_i (start_reg + rd_idx_reg),
      .rd_data_o (ram_q)
   );
   assign ram_pad = PADW'(ram_q);

   // Interrupt status, set wins over a write-one clear
   assign irq_set[`ELA_IRQ_TRIG] = final_hit;
   assign irq_set[`ELA_IRQ_DONE] = (state_reg == ELA_POST)
                                   && post_reg == AW'(1) && !abort_pulse
                                   && !start_run;
   assign irq_clr = (wr.en && wr.addr == `ELA_ADDR_IRQ_STAT)
                    ? (wr.data[1:0] & wr.bm[1:0]) : 2'h0;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= `ELA_IRQ_RST;
         irq_mask_reg <= `ELA_IRQ_RST;
         irq_o        <= 1'b0;
      end else begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         if (wr.en && wr.addr == `ELA_ADDR_IRQ_MASK) begin
            irq_mask_reg <= merge({30'h0, irq_mask_reg})[1:0];
         end
         irq_o <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_mask_reg);
      end
   end

endmodule : ela_top

// >>> testbench/ela_jtag_host.sv
// Host debugger model scanning the analyzer's user chain
module ela_jtag_host
   import ela_pkg::*;
(
   output ela_jtag_s        jtag_o,
   input  wire logic        tdo_i
);
   timeunit 1ns;
   timeprecision 1ns;

   initial jtag_o = '0;

   // Link clock only runs inside a frame
   task automatic pulse();
      #80 jtag_o.tck = 1'b1;
      #80 jtag_o.tck = 1'b0;
   endtask : pulse

   // Capture, 45 shifts LSB first, update
   task automatic scan(input logic sel, input logic [44:0] dr,
                       output logic [44:0] q);
      jtag_o.sel = sel;
      jtag_o.capture = 1'b1;
      pulse();
      jtag_o.capture = 1'b0;
      jtag_o.shift = 1'b1;
      for (int i = 0; i < 45; i++) begin
         jtag_o.tdi = dr[i];
         #80 q[i] = tdo_i;
         jtag_o.tck = 1'b1;
         #80 jtag_o.tck = 1'b0;
      end
      jtag_o.tdi = ~dr[44];
      jtag_o.shift = 1'b0;
      jtag_o.update = 1'b1;
      pulse();
      jtag_o.update = 1'b0;
      #160 jtag_o.sel = 1'b0;
   endtask : scan
endmodule : ela_jtag_host

// >>> testbench/ela_top_assertions.sv
// Port-level checks of the logic analyzer
module ela_top_assertions
   import ela_pkg::*;
#(
   parameter int SW = 8
) (
   input wire logic                    clk_i,
   input wire logic                    rst_i,
   input wire logic                    wb_cyc_i,
   input wire logic                    wb_stb_i,
   input wire logic                    wb_we_i,
   input wire logic [31:0]             wb_dat_o,
   input wire logic                    wb_ack_o,
   input wire logic                    irq_o,
   input wire ela_jtag_s               jtag_i,
   input wire logic                    jtag_tdo_o,
   input wire logic [(SW>0?SW:1)-1:0]  stim_o
);
   timeunit 1ns;
   timeprecision 1ns;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held too long");
   a_ack_timely: assert property
      (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing");
   a_ack_cause: assert property
      (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   a_dat_hold: assert property
      (!wb_ack_o && !$past(rst_i) |-> $stable(wb_dat_o))
      else $error("read data moved");
   a_reset_quiet: assert property
      ($fell(rst_i) |-> !wb_ack_o && !irq_o && stim_o == '0)
      else $error("outputs not cleared");
   a_stim_hold: assert property
      (!$past(wb_ack_o && wb_we_i) && !jtag_i.sel |-> $stable(stim_o))
      else $error("stimulus moved");
   a_irq_clear: assert property
      ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i) || jtag_i.sel)
      else $error("irq dropped alone");
   a_tdo_idle: assert property
      (!jtag_i.sel [*8] |=> $stable(jtag_tdo_o))
      else $error("tdo moved unselected");

   c_irq: cover property ($rose(irq_o));
   c_stim: cover property ($changed(stim_o));
   c_update: cover property (jtag_i.sel && jtag_i.update);
endmodule : ela_top_assertions

// >>> testbench/tb_top.sv
// Self-checking bench of the logic analyzer
`include "ela_consts.svh"
module tb_top
   import ela_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [11:0] wb_adr_i = '0;
   logic [31:0] wb_dat_i = '0;
   logic [3:0]  wb_sel_i = 4'hf;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        irq_o;
   logic        jtag_tdo_o;
   ela_jtag_s   jtag_i;
   logic [31:0] mon_i = '0;
   logic [7:0]  trig_i = '0;
   logic [7:0]  stim_o;
   int          n_fail = 0;
   int          n_tests = 0;
   int          cyc_cnt = 0;

   initial begin
      forever #10 clk_i = ~clk_i;
   end

   always @(posedge clk_i) begin
      mon_i <= mon_i + 32'h1;
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 20000) begin
         n_fail++;
         report_and_stop();
      end
   end

   ela_top #(.DEPTH(512), .INIT_ARM(1'b1),
      .INIT_MASK(64'h1), .INIT_MODE(96'h2)) dut_u (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .irq_o(irq_o), .jtag_i(jtag_i),
      .jtag_tdo_o(jtag_tdo_o), .mon_i(mon_i), .trig_i(trig_i),
      .stim_o(stim_o));

   ela_jtag_host host_u (.jtag_o(jtag_i), .tdo_i(jtag_tdo_o));

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_tests++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk

   // Classic Wishbone single cycle
   task automatic wb(input logic we, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb

   initial begin : main
      logic [31:0] q;
      logic [31:0] s0;
      logic [44:0] j;
      int          ix [3] = '{1, 2, 511};
      logic [31:0] cfg [9] = '{32'h1, 32'h2, 32'h0, 32'h6, 32'h4,
                               32'h0, 32'h3, 32'hb, 32'h1};
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      wb(1'b0, `ELA_ADDR_STATUS, 32'h0, q);
      chk(q, 32'h1);
      wb(1'b0, 12'h0fc, 32'h0, q);
      chk(q, 32'h0);
      wb(1'b1, `ELA_ADDR_STIM_BASE, 32'h5a, q);
      wb_sel_i <= 4'h2;
      wb(1'b1, `ELA_ADDR_STIM_BASE, 32'hffffffff, q);
      wb_sel_i <= 4'hf;
      wb(1'b0, `ELA_ADDR_STIM_BASE, 32'h0, q);
      chk(q, 32'hff5a);
      for (int c = 0; c < 3; c++) begin
         wb(1'b1, 12'h100 + 12'(32 * c), cfg[3 * c], q);
         wb(1'b1, 12'h108 + 12'(32 * c), cfg[3 * c + 1], q);
         wb(1'b1, 12'h114 + 12'(32 * c), cfg[3 * c + 2], q);
      end
      wb(1'b1, `ELA_ADDR_IRQ_MASK, 32'h3, q);
      chk(32'(stim_o), 32'h5a);
      wb(1'b1, `ELA_ADDR_CTRL, 32'h301, q);
      trig_i <= 8'h1;
      wb(1'b0, `ELA_ADDR_STATUS, 32'h0, q);
      chk(q, 32'h11);
      trig_i <= 8'h3;
      wb(1'b0, `ELA_ADDR_STATUS, 32'h0, q);
      chk(q, 32'h21);
      trig_i <= 8'h2;
      s0 = mon_i + 32'h1;
      q = '0;
      for (int i = 0; i < 400 && q[1:0] !== 2'h3; i++) begin
         wb(1'b0, `ELA_ADDR_STATUS, 32'h0, q);
      end
      chk(q & 32'h103, 32'h103);
      chk(32'(irq_o), 32'h1);
      wb(1'b1, `ELA_ADDR_RD_IDX, 32'h0, q);
      wb(1'b0, `ELA_ADDR_RD_DATA, 32'h0, q);
      chk(q, s0);
      for (int k = 0; k < 3; k++) begin
         wb(1'b1, `ELA_ADDR_RD_IDX, ix[k], q);
         wb(1'b0, `ELA_ADDR_RD_DATA, 32'h0, q);
         chk(q, s0 + ix[k]);
      end
      wb(1'b1, `ELA_ADDR_IRQ_STAT, 32'h1, q);
      wb(1'b0, `ELA_ADDR_IRQ_STAT, 32'h0, q);
      chk(q, 32'h2);
      wb(1'b1, `ELA_ADDR_IRQ_STAT, 32'h2, q);
      wb(1'b0, `ELA_ADDR_IRQ_STAT, 32'h0, q);
      chk(32'(irq_o), 32'h0);
      host_u.scan(1'b1, {1'b1, `ELA_ADDR_IRQ_MASK, 32'h0}, j);
      wb(1'b0, `ELA_ADDR_IRQ_MASK, 32'h0, q);
      chk(q, 32'h0);
      host_u.scan(1'b0, {1'b1, `ELA_ADDR_IRQ_MASK, 32'h3}, j);
      wb(1'b0, `ELA_ADDR_IRQ_MASK, 32'h0, q);
      chk(q, 32'h0);
      host_u.scan(1'b1, {1'b0, `ELA_ADDR_STATUS, 32'h0}, j);
      host_u.scan(1'b1, {1'b0, `ELA_ADDR_STATUS, 32'h0}, j);
      chk(j[31:0] & 32'h3, 32'h3);
      // Repeat mode with a quarter of pre-trigger storage
      wb(1'b1, `ELA_ADDR_CTRL, 32'h112, q);
      repeat (200) @(posedge clk_i);
      trig_i <= 8'h3;
      s0 = mon_i + 32'h1;
      q = '0;
      for (int i = 0; i < 400 && q[1:0] !== 2'h3; i++) begin
         wb(1'b0, `ELA_ADDR_STATUS, 32'h0, q);
      end
      chk(q & 32'h103, 32'h103);
      wb(1'b1, `ELA_ADDR_RD_IDX, 32'h80, q);
      wb(1'b0, `ELA_ADDR_RD_DATA, 32'h0, q);
      chk(q, s0);
      wb(1'b1, `ELA_ADDR_RD_IDX, 32'h0, q);
      wb(1'b0, `ELA_ADDR_RD_DATA, 32'h0, q);
      chk(q, s0 - 32'h80);
      wb(1'b1, `ELA_ADDR_IRQ_STAT, 32'h3, q);
      wb(1'b0, `ELA_ADDR_STATUS, 32'h0, q);
      chk(q, 32'h1);
      report_and_stop();
   end
endmodule : tb_top

bind ela_top ela_top_assertions #(.SW(SW)) chk_u (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .irq_o(irq_o), .jtag_i(jtag_i),
   .jtag_tdo_o(jtag_tdo_o), .stim_o(stim_o));
